// [rtl/fsc_pkg.sv]
package fsc_pkg;

    // ********************************************************************
    // Register addresses
    // ********************************************************************
    localparam logic [7:0] ADDR_CONFIG = 8'h03;
    localparam logic [7:0] ADDR_CONFIG_ALT = 8'h09;
    localparam logic [7:0] ADDR_ONE_SHOT = 8'h0F;
    localparam logic [7:0] ADDR_CRIT_LIMIT = 8'h19;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h46;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h47;
    localparam logic [7:0] ADDR_TACH_SETUP = 8'h4D;

    // ********************************************************************
    // Configuration field positions and reset values
    // ********************************************************************
    localparam int CFG_ALARM_MASK = 7;
    localparam int CFG_STANDBY = 6;
    localparam int CFG_FAN_OFF_STANDBY = 5;
    localparam int CFG_PIN_IS_TACH = 2;
    localparam int CFG_CRIT_OVERRIDE = 1;
    localparam int CFG_FAULT_FILTER = 0;
    localparam logic [7:0] CFG_WRITE_MASK = 8'hE7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CRIT_LIMIT_RESET = 8'h55;
    localparam logic [1:0] EDGE_CODE_RESET = 2'h1;
    localparam logic [1:0] FAULT_RUN_LEN = 2'h3;
    localparam int COUNT_LOW_DROP = 2;

    // ********************************************************************
    // Fan period measurement timing
    // ********************************************************************
    localparam int CLK_HZ = 200_000_000;
    localparam int TACH_TICK_HZ = 90_000;
    localparam int TACH_TICK_CYCLES = CLK_HZ / TACH_TICK_HZ;

    typedef enum logic [1:0] {
        FSC_EDGES_RSVD,
        FSC_EDGES_2,
        FSC_EDGES_3,
        FSC_EDGES_5
    } fsc_edge_code_t;

endpackage

// [rtl/fsc_tach_period.sv]
module fsc_tach_period
    import fsc_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int TICK_CYCLES = TACH_TICK_CYCLES
) (
    input wire logic clk, // Device clock
    input wire logic srst, // Sync reset, active high
    input wire logic enable, // Pin is a tach input
    input wire logic tachIn, // Tach pin level
    input wire logic [1:0] edgeCode, // Edges per measurement
    input wire logic clock360k, // Fan clock is 360 kHz
    output logic [CNT_W-1:0] period // Latest scaled period count
);
    // A count narrower than a byte or a zero prescaler cannot be served
    if (CNT_W < 8 || TICK_CYCLES < 1) begin : g_bad_params
        $error("fsc_tach_period: bad parameters");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT_FIRST, ST_COUNT} fsc_tach_state_t;

    fsc_tach_state_t state;
    logic tachPrev;
    logic [$clog2(TICK_CYCLES+1)-1:0] divCnt;
    logic [CNT_W-1:0] raw;
    logic [2:0] edgesLeft;
    logic rise;
    logic tick;
    logic [2:0] edgeTarget;
    logic [1:0] shift;
    logic [CNT_W+2:0] scaled;

    assign rise = tachIn & ~tachPrev;
    assign tick = (divCnt == '0);

    // Edge code to edge count and count multiple
    always_comb begin
        case (edgeCode)
            2'b10: begin edgeTarget = 3'd3; shift = 2'd1; end
            2'b11: begin edgeTarget = 3'd5; shift = 2'd0; end
            default: begin edgeTarget = 3'd2; shift = 2'd2; end // reserved 00 treated as 01
        endcase
        if (clock360k) begin
            shift = 2'd0; // Multiple of one at the fast fan clock
        end
        scaled = {3'b000, raw} << shift;
    end

    // Edge history; starts at the pulled-up idle level so reset makes no false edge
    always_ff @(posedge clk) begin
        if (srst) begin
            tachPrev <= 1'b1;
        end else begin
            tachPrev <= tachIn;
        end
    end

    // Tick prescaler sets the count resolution
    always_ff @(posedge clk) begin
        if (srst || tick) begin
            divCnt <= ($clog2(TICK_CYCLES+1))'(TICK_CYCLES - 1);
        end else begin
            divCnt <= divCnt - 1'b1;
        end
    end

    // Measure ticks from the first edge to the last counted edge
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            raw <= '0;
            edgesLeft <= '0;
            period <= '1;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (enable) state <= ST_WAIT_FIRST;
                end
                ST_WAIT_FIRST: begin
                    if (!enable) begin
                        state <= ST_IDLE;
                    end else if (rise) begin
                        raw <= '0;
                        edgesLeft <= edgeTarget - 3'd1;
                        state <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (!enable) begin
                        state <= ST_IDLE;
                    end else begin
                        // Saturate so a very slow fan reads full scale
                        if (tick && raw != '1) raw <= raw + 1'b1;
                        if (rise) begin
                            if (edgesLeft == 3'd1) begin
                                period <= (|scaled[CNT_W+2:CNT_W]) ? '1 : scaled[CNT_W-1:0];
                                state <= ST_WAIT_FIRST;
                            end else begin
                                edgesLeft <= edgesLeft - 3'd1;
                            end
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

endmodule // fsc_tach_period

// [rtl/fsc_config_tach.sv]
module fsc_config_tach
    import fsc_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int TICK_CYCLES = TACH_TICK_CYCLES
) (
    input wire logic clk, // Device clock, 200 MHz
    input wire logic srst, // Power-on reset, sync, active high
    input wire logic [7:0] regAddr, // Register address from bus controller
    input wire logic [7:0] regWrData, // Write byte
    input wire logic regWrite, // Write strobe, one cycle
    input wire logic regRead, // Read strobe, one cycle
    output logic [7:0] regRdData, // Read byte, valid cycle after strobe
    input wire logic resultValid, // Remote conversion finished, pulse
    input wire logic resultOutside, // That result is outside the window
    input wire logic convDone, // Conversion engine idle again, pulse
    input wire logic tachPinIn, // Shared pin input level
    input wire logic clock360k, // Fan clock select is 360 kHz
    output logic alarmPinOut, // Shared pin drive value, always low
    output logic alarmPinOe, // Shared pin pulled low when high
    output logic convContinuous, // Continuous conversions enabled
    output logic convStartOnce, // Single conversion request, pulse
    output logic standby, // Low-power standby active
    output logic fanForceOff, // Fan output forced to disabled level
    output logic [7:0] critLimit // Remote critical temperature limit
);
    // Byte lanes of the count registers assume a 16-bit count
    if (CNT_W != 16) begin : g_bad_cnt_w
        $error("fsc_config_tach: count must be 16 bits");
    end

    // ********************************************************************
    // Storage
    // ********************************************************************
    logic [7:0] config_;
    logic [1:0] edgeCode;
    logic critUsed;
    logic [1:0] faultRun;
    logic alarmActive;
    logic [7:0] countHighLatch;
    logic [CNT_W-1:0] period;
    logic next_oneShot;
    logic critTake;

    // ********************************************************************
    // Register writes
    // ********************************************************************
    // Both addresses reach one config register, unused bits held zero
    always_ff @(posedge clk) begin
        if (srst) begin
            config_ <= CFG_RESET;
        end else if (regWrite && (regAddr == ADDR_CONFIG || regAddr == ADDR_CONFIG_ALT)) begin
            config_ <= regWrData & CFG_WRITE_MASK;
        end
    end

    // Edge-count field
    always_ff @(posedge clk) begin
        if (srst) begin
            edgeCode <= EDGE_CODE_RESET;
        end else if (regWrite && regAddr == ADDR_TACH_SETUP && regWrData[1:0] != 2'b00) begin
            edgeCode <= regWrData[1:0]; // reserved code ignored
        end
    end

    // Accepted only with the override bit set and the lock still open
    assign critTake = regWrite && regAddr == ADDR_CRIT_LIMIT && config_[CFG_CRIT_OVERRIDE]
                      && !critUsed;

    // One-time critical limit; only power-on reset reopens it
    always_ff @(posedge clk) begin
        if (srst) begin
            critLimit <= CRIT_LIMIT_RESET;
        end else if (critTake) begin
            critLimit <= regWrData;
        end
    end

    // Lock flag; the bus can never clear it, so a second write stays refused
    always_ff @(posedge clk) begin
        if (srst) begin
            critUsed <= 1'b0;
        end else if (critTake) begin
            critUsed <= 1'b1;
        end
    end

    // ********************************************************************
    // Conversion control
    // ********************************************************************
    // A one-shot is refused outside standby or while one is still running
    logic shotBusy;
    assign next_oneShot = regWrite && regAddr == ADDR_ONE_SHOT && config_[CFG_STANDBY]
                          && !shotBusy;

    // Mode outputs follow the standby bit two cycles after the write
    always_ff @(posedge clk) begin
        if (srst) begin
            convContinuous <= 1'b1;
            standby <= 1'b0;
        end else begin
            convContinuous <= !config_[CFG_STANDBY];
            standby <= config_[CFG_STANDBY];
        end
    end

    // Single-shot request, one cycle wide
    always_ff @(posedge clk) begin
        if (srst) begin
            convStartOnce <= 1'b0;
        end else begin
            convStartOnce <= next_oneShot;
        end
    end

    // Busy from the accepted request until the engine reports done
    always_ff @(posedge clk) begin
        if (srst) begin
            shotBusy <= 1'b0;
        end else if (next_oneShot) begin
            shotBusy <= 1'b1;
        end else if (convDone) begin
            shotBusy <= 1'b0;
        end
    end

    // Fan held at its disabled level only while standing by
    always_ff @(posedge clk) begin
        if (srst) begin
            fanForceOff <= 1'b0;
        end else begin
            fanForceOff <= config_[CFG_STANDBY] && config_[CFG_FAN_OFF_STANDBY];
        end
    end

    // ********************************************************************
    // Remote fault filter and shared pin
    // ********************************************************************
    // Run of consecutive outside results, saturating at the filter length
    always_ff @(posedge clk) begin
        if (srst) begin
            faultRun <= '0;
        end else if (resultValid) begin
            if (!resultOutside) begin
                faultRun <= '0;
            end else if (faultRun != FAULT_RUN_LEN) begin
                faultRun <= faultRun + 2'd1;
            end
        end
    end

    // Alarm flag; an inside result clears it, comparator style
    always_ff @(posedge clk) begin
        if (srst) begin
            alarmActive <= 1'b0;
        end else if (resultValid) begin
            if (!resultOutside) begin
                alarmActive <= 1'b0;
            end else if (!config_[CFG_FAULT_FILTER]) begin
                alarmActive <= 1'b1;
            end else if (faultRun >= FAULT_RUN_LEN - 2'd1) begin
                alarmActive <= 1'b1; // third in a row
            end
        end
    end

    // Drive value of the open-drain pin is fixed low
    always_ff @(posedge clk) begin
        if (srst) begin
            alarmPinOut <= 1'b0;
        end else begin
            alarmPinOut <= 1'b0;
        end
    end

    // Open drain: only ever pulls low, never in tach mode or when masked
    always_ff @(posedge clk) begin
        if (srst) begin
            alarmPinOe <= 1'b0;
        end else begin
            alarmPinOe <= alarmActive && !config_[CFG_ALARM_MASK]
                          && !config_[CFG_PIN_IS_TACH];
        end
    end

    // ********************************************************************
    // Fan period count
    // ********************************************************************
    fsc_tach_period #(
        .CNT_W(CNT_W),
        .TICK_CYCLES(TICK_CYCLES)
    ) u_period (
        .clk(clk),
        .srst(srst),
        .enable(config_[CFG_PIN_IS_TACH]),
        .tachIn(tachPinIn),
        .edgeCode(edgeCode),
        .clock360k(clock360k),
        .period(period)
    );

    // Low byte read freezes the high byte of the same measurement
    always_ff @(posedge clk) begin
        if (srst) begin
            countHighLatch <= '1;
        end else if (regRead && regAddr == ADDR_COUNT_LOW) begin
            countHighLatch <= period[15:8];
        end
    end

    // Registered read data; unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (srst) begin
            regRdData <= '0;
        end else if (regRead) begin
            case (regAddr)
                ADDR_CONFIG, ADDR_CONFIG_ALT: regRdData <= config_;
                ADDR_CRIT_LIMIT: regRdData <= critLimit;
                ADDR_TACH_SETUP: regRdData <= {6'b00_0000, edgeCode};
                ADDR_COUNT_LOW: regRdData <= {period[7:COUNT_LOW_DROP], 2'b00};
                ADDR_COUNT_HIGH: regRdData <= countHighLatch;
                default: regRdData <= '0;
            endcase
        end
    end

endmodule // fsc_config_tach

// [test/fsc_config_tach_monitor.sv]
module fsc_config_tach_monitor
    import fsc_pkg::*;
(
    input wire logic clk, // Device clock
    input wire logic srst, // Sync reset
    input wire logic [7:0] regAddr, // Bus address
    input wire logic [7:0] regWrData, // Write byte
    input wire logic regWrite, // Write strobe
    input wire logic regRead, // Read strobe
    input wire logic [7:0] regRdData, // Read byte
    input wire logic resultValid, // Result pulse
    input wire logic resultOutside, // Result out of window
    input wire logic alarmPinOut, // Pin drive value
    input wire logic alarmPinOe, // Pin pull-low enable
    input wire logic convContinuous, // Continuous mode
    input wire logic convStartOnce, // One-shot pulse
    input wire logic standby, // Standby
    input wire logic fanForceOff, // Fan forced off
    input wire logic [7:0] critLimit // Critical limit
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    logic critUsed;
    // Remembers the one allowed limit change
    always_ff @(posedge clk) begin
        if (srst) begin
            critUsed <= 1'b0;
        end else if ($changed(critLimit)) begin
            critUsed <= 1'b1;
        end
    end
    // ****
    // Steps
    // ****
    sequence cfg_wr;
        regWrite && (regAddr == ADDR_CONFIG || regAddr == ADDR_CONFIG_ALT);
    endsequence
    sequence shot_wr;
        regWrite && regAddr == ADDR_ONE_SHOT;
    endsequence
    a_standby_follows: assert property (cfg_wr |-> ##2 standby == $past(regWrData[6], 2))
        else $error("standby does not follow config write");
    a_fan_off_follows: assert property (cfg_wr |-> ##2
        fanForceOff == ($past(regWrData[6], 2) && $past(regWrData[5], 2)))
        else $error("fan force-off wrong after config write");
    a_cont_inverse: assert property (convContinuous != standby)
        else $error("continuous and standby agree");
    a_shot_cause: assert property (convStartOnce |-> standby ##0 $past(regWrite &&
        regAddr == ADDR_ONE_SHOT) ##1 !convStartOnce)
        else $error("one-shot pulse without cause or too long");
    a_pin_low_only: assert property (!alarmPinOut)
        else $error("alarm pin drives high");
    a_inside_clears: assert property (resultValid && !resultOutside |-> ##2 !alarmPinOe)
        else $error("in-window result leaves alarm");
    a_limit_once: assert property ($changed(critLimit) |-> !critUsed &&
        $past(regWrite && regAddr == ADDR_CRIT_LIMIT))
        else $error("critical limit changed illegally");
    a_read_holds: assert property (!$past(regRead) |-> $stable(regRdData))
        else $error("read data moved without read");
    a_unused_zero: assert property (regRead && (regAddr == ADDR_CONFIG ||
        regAddr == ADDR_CONFIG_ALT) |=> regRdData[4:3] == 2'b00)
        else $error("unused config bits not zero");
    a_low_bits_zero: assert property (regRead && regAddr == ADDR_COUNT_LOW |=>
        regRdData[1:0] == 2'b00)
        else $error("count low bits not zero");
    c_shot: cover property (shot_wr ##1 convStartOnce);
endmodule // fsc_config_tach_monitor

bind fsc_config_tach fsc_config_tach_monitor i_fsc_config_tach_monitor (
    .clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .resultValid(resultValid), .resultOutside(resultOutside), .alarmPinOut(alarmPinOut),
    .alarmPinOe(alarmPinOe), .convContinuous(convContinuous),
    .convStartOnce(convStartOnce), .standby(standby), .fanForceOff(fanForceOff),
    .critLimit(critLimit)
);

// [test/fsc_fan_engine_model.sv]
module fsc_fan_engine_model #(
    parameter int HALF = 40 // Tach half period, clock cycles
) (
    input wire logic clk, // Device clock
    input wire logic srst, // Sync reset
    input wire logic convStartOnce, // One-shot request
    input wire logic fanSpin, // Fan running
    output logic convDone, // Conversion finished pulse
    output logic tachOut // Tach pulse, pulled up when idle
);
    timeunit 1ns;
    timeprecision 1ps;
    int busy;
    int phase;
    // One-shot takes three cycles, so a quick second request lands while busy
    always_ff @(posedge clk) begin
        if (srst || convStartOnce) begin
            busy <= srst ? 0 : 3;
        end else if (busy > 0) begin
            busy <= busy - 1;
        end
        convDone <= (busy == 1);
    end
    // Stopped fan leaves the pull-up level, not the last value
    always_ff @(posedge clk) begin
        phase <= (!fanSpin || phase == 2 * HALF - 1) ? 0 : phase + 1;
        tachOut <= !fanSpin || (phase < HALF);
    end
endmodule // fsc_fan_engine_model

// [test/testbench.sv]
module testbench;
    import fsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, srst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic resultValid = 1'b0, resultOutside = 1'b0, clock360k = 1'b0, fanSpin = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, critLimit, lowB;
    logic convDone, tachOut, tachPinIn, alarmPinOut, alarmPinOe;
    logic convContinuous, convStartOnce, standby, fanForceOff;
    logic [15:0] cnt;
    int fails = 0, checks = 0, shots = 0, base;
    logic [1:0] codeTab [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h1};
    logic spdTab [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    int expTab [5] = '{20, 40, 80, 80, 80};
    always #2.5 clk = ~clk;
    // Shared pin: our pull-low wins over the fan's pulse
    assign tachPinIn = alarmPinOe ? 1'b0 : tachOut;
    // Counts one-shot pulses
    always @(posedge clk) if (convStartOnce === 1'b1) shots++;
    fsc_config_tach #(.TICK_CYCLES(4)) i_fsc_config_tach (.clk(clk), .srst(srst),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .resultValid(resultValid), .resultOutside(resultOutside),
        .convDone(convDone), .tachPinIn(tachPinIn), .clock360k(clock360k),
        .alarmPinOut(alarmPinOut), .alarmPinOe(alarmPinOe), .convContinuous(convContinuous),
        .convStartOnce(convStartOnce), .standby(standby), .fanForceOff(fanForceOff),
        .critLimit(critLimit));
    fsc_fan_engine_model i_fsc_fan_engine_model (.clk(clk), .srst(srst),
        .convStartOnce(convStartOnce), .fanSpin(fanSpin), .convDone(convDone),
        .tachOut(tachOut));
    // ****
    // Bus and compare tasks
    // ****
    task automatic chk8(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkr(input logic [15:0] got, input int lo, input int hi);
        chk8(got, (got >= lo && got <= hi) ? got : 16'(lo));
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 d = regRdData;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk8(d, e);
    endtask
    task automatic wt;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic res(input logic o);
        @(posedge clk);
        resultValid <= 1'b1;
        resultOutside <= o;
        @(posedge clk);
        resultValid <= 1'b0;
        wt();
    endtask
    task automatic end_sim;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Cuts a hang short; tests need about 5200 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_sim();
    end
    // ****
    // Tests
    // ****
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rdc(ADDR_CONFIG, CFG_RESET);
        rdc(ADDR_COUNT_HIGH, 8'hFF);
        rdc(8'h7E, 8'h00);
        chk8(critLimit, CRIT_LIMIT_RESET);
        chk8(convContinuous, 1'b1);
        $display("test reset done");
        wr(ADDR_CONFIG_ALT, 8'hFF);
        wt();
        rdc(ADDR_CONFIG, 8'hE7);
        chk8({standby, convContinuous, fanForceOff}, 3'b101);
        wr(ADDR_CONFIG, 8'hC0);
        wt();
        chk8({standby, fanForceOff}, 2'b10);
        base = shots;
        wr(ADDR_ONE_SHOT, 8'h5A);
        wr(ADDR_ONE_SHOT, 8'h00);
        repeat (10) @(posedge clk);
        wr(ADDR_ONE_SHOT, 8'hFF);
        wr(ADDR_CONFIG, 8'h80);
        repeat (10) @(posedge clk);
        wr(ADDR_ONE_SHOT, 8'h11);
        wt();
        chk8(shots - base, 2);
        $display("test config done");
        res(1'b1);
        chk8(alarmPinOe, 1'b0);
        wr(ADDR_CONFIG, 8'h00);
        res(1'b0);
        chk8(alarmPinOe, 1'b0);
        res(1'b1);
        chk8(alarmPinOe, 1'b1);
        wr(ADDR_CONFIG, 8'h01);
        res(1'b0);
        res(1'b1);
        res(1'b1);
        chk8(alarmPinOe, 1'b0);
        res(1'b1);
        chk8(alarmPinOe, 1'b1);
        res(1'b0);
        wr(ADDR_CONFIG, 8'h04);
        res(1'b1);
        chk8(alarmPinOe, 1'b0);
        $display("test alarm done");
        wr(ADDR_CRIT_LIMIT, 8'h40);
        wt();
        chk8(critLimit, 8'h55);
        wr(ADDR_CONFIG, 8'h02);
        wr(ADDR_CRIT_LIMIT, 8'h46);
        wt();
        chk8(critLimit, 8'h46);
        wr(ADDR_CRIT_LIMIT, 8'h30);
        wt();
        chk8(critLimit, 8'h46);
        // Power cycle stand-in, driven on the rising edge like the bus and result inputs
        @(posedge clk);
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        wt();
        chk8(critLimit, 8'h55);
        $display("test limit done");
        wr(ADDR_CONFIG, 8'h04);
        fanSpin <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            clock360k <= spdTab[i];
            wr(ADDR_TACH_SETUP, {6'h00, codeTab[i]});
            repeat (1000) @(posedge clk);
            rd(ADDR_COUNT_LOW, lowB);
            rd(ADDR_COUNT_HIGH, cnt[15:8]);
            cnt[7:0] = lowB;
            chkr(cnt, expTab[i] * 9 / 10 - 4, expTab[i] * 11 / 10 + 4);
        end
        $display("test tach done");
        end_sim();
    end
endmodule // testbench
